// *** core/sbm_pkg.sv ***
// Package for the single-button setup menu: timing counts, page codes, settings carrier.
// Assumes a 100 MHz system clock; all times are derived here from their printed figures.
package sbm_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_HOLD_PAGE = 5000;
  localparam int MS_RED_PHASE = 200;
  localparam int MS_GRN_PHASE = 500;
  localparam int MS_IDLE = 10000;
  localparam int MS_FAULT = 60000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CYC_RED_PHASE = MS_RED_PHASE * CYC_PER_MS;
  localparam int CYC_GRN_PHASE = MS_GRN_PHASE * CYC_PER_MS;
  localparam int CYC_PER_S = 1000 * CYC_PER_MS;
  localparam int S_HOLD_PAGE = MS_HOLD_PAGE / 1000;
  localparam int S_IDLE = MS_IDLE / 1000;
  localparam int S_FAULT = MS_FAULT / 1000;
  localparam int PAGE_MAX_S = 45;
  localparam int RED_BLINKS = 2;
  localparam logic [3:0] PP_DEFAULT = 4'h8;
  localparam logic [3:0] PP_CONT = 4'h7;
  localparam logic [1:0] IM_DEFAULT = 2'h2;
  localparam logic [1:0] SD_DEFAULT = 2'h1;
  localparam logic LP_DEFAULT = 1'b0;

  typedef enum logic [2:0] {
    SBM_PG_NONE = 3'h0,
    SBM_PG_SHUT = 3'h1,
    SBM_PG_PURGE = 3'h2,
    SBM_PG_INTER = 3'h3,
    SBM_PG_DELAY = 3'h4,
    SBM_PG_LONG = 3'h5,
    SBM_PG_LOG = 3'h6,
    SBM_PG_CLEAR = 3'h7
  } sbm_page_t;

  // Stored menu settings as seen by the burner sequencer
  typedef struct packed {
    logic [3:0] purge_code;   // 1..6 minutes, 7 continuous, 8 off
    logic [1:0] inter_code;   // 1 hourly, 2 daily
    logic [1:0] delay_code;   // 1 8 s, 2 20 s, 3 35 s
    logic long_purge;
  } sbm_cfg_t;

  // One-cycle command pulses toward the sequencer and counters
  typedef struct packed {
    logic shut_test;
    logic clr_log;
    logic clr_lock_cnt;
    logic clr_hours;
    logic clr_heat_cnt;
  } sbm_cmd_t;

  function automatic int page_max(input sbm_page_t p);
    case (p)
      SBM_PG_PURGE: page_max = 8;
      SBM_PG_INTER: page_max = 2;
      SBM_PG_DELAY: page_max = 3;
      SBM_PG_LONG: page_max = 2;
      SBM_PG_LOG: page_max = 10;
      SBM_PG_CLEAR: page_max = 5;
      default: page_max = 0;
    endcase
  endfunction
endpackage

// *** core/sbm_menu.sv ***
// Single-button setup menu of a burner control box: hold time picks a page, presses pick a value.
// Assumes a debounced-free raw button and heat request from pins; both pass two flip-flops here.
//
// Contract
// - Hold 5..10 s selects shutdown test; two red blinks 0.2 s on/off.
// - Release on shutdown page triggers shutdown, restart and recycle count reload.
// - Shutdown page exits without any confirmation blinking.
// - Hold 10..15 s opens post-purge page, one green blink, then green off.
// - Post-purge presses 1-6 minutes, 7 continuous, 8 disabled; default disabled.
// - While counting presses green follows the button.
// - 10 s after last press, green blinks press count, 0.5 s on/off.
// - Heat request loss during post-purge entry discards; during blinking still stores.
// - Hold 20..25 s: intermittent page, three blinks; 1 hourly, 2 daily default.
// - New intermittent setting takes effect only after heat request, test, flame loss, power.
// - Hold 25..30 s: second-stage delay page, four blinks; 8, 20, 35 s.
// - Hold 30..35 s: long pre-purge page, five blinks; 1 enables, 2 disables.
// - Hold 35..40 s: log page, six blinks, show lockout 10 s, a press ends the show.
// - Log page presses 1..10 select newest through oldest stored lockout.
// - After display, press within 10 s returns to entry; 10 s silence closes menu. Here 10 s silence also returns to entry; a further 10 s there closes.
// - Hold 40..45 s: reset page, seven blinks; 1-5 presses clear items or defaults.
// - Menu works both in standby and while burner operates.
// - No press within 10 s on a settings page exits and blinks the stored setting; log and reset pages just exit.
// - Too many presses store the page maximum.
// - Press held over 60 s reports a reset-button fault.
`timescale 1ns/1ps
module sbm_menu #(
  parameter int CYC_SEC = sbm_pkg::CYC_PER_S,
  parameter int CYC_RED = sbm_pkg::CYC_RED_PHASE,
  parameter int CYC_GRN = sbm_pkg::CYC_GRN_PHASE
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_button,
  input wire logic i_heat_request_thermostat,
  input wire logic i_flame_loss,
  input wire logic [3:0] i_log_type,
  output logic [3:0] o_log_index,
  output logic o_log_show,
  output logic [3:0] o_log_shown_type,
  output logic o_led_red,
  output logic o_led_green,
  output logic o_button_fault,
  output sbm_pkg::sbm_cfg_t o_cfg,
  output logic [1:0] o_inter_active,
  output sbm_pkg::sbm_cmd_t o_cmd
);
  typedef enum logic [6:0] {
    SBM_IDLE = 7'b000_0001,
    SBM_HOLD = 7'b000_0010,
    SBM_PAGE_BLINK = 7'b000_0100,
    SBM_ENTRY = 7'b000_1000,
    SBM_CONFIRM = 7'b001_0000,
    SBM_SHOW = 7'b010_0000,
    SBM_FAULT = 7'b100_0000
  } sbm_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic btn_meta, btn, btn_prev, ht_meta, ht, ht_prev;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      btn_meta <= 1'b0;
      btn <= 1'b0;
      btn_prev <= 1'b0;
      ht_meta <= 1'b0;
      ht <= 1'b0;
      ht_prev <= 1'b0;
    end
    else
    begin
      btn_meta <= i_button;
      btn <= btn_meta;
      btn_prev <= btn;
      ht_meta <= i_heat_request_thermostat;
      ht <= ht_meta;
      ht_prev <= ht;
    end
  end
  wire btn_rise = btn & ~btn_prev;
  wire btn_fall = ~btn & btn_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Menu state
  sbm_state_t state, next_state;
  sbm_pkg::sbm_page_t page, next_page;
  logic [31:0] tick, next_tick;       // cycles within the current second or blink phase
  logic [5:0] secs, next_secs;        // whole seconds in hold or idle wait
  logic [3:0] presses, next_presses;
  logic [4:0] blinks, next_blinks;    // blink phases left (2 per blink); 8 blinks need 5 bits
  logic red_mode, next_red_mode;
  sbm_pkg::sbm_cfg_t cfg, next_cfg;
  logic [1:0] inter_act, next_inter_act;
  sbm_pkg::sbm_cmd_t next_cmd;
  logic [3:0] log_idx, next_log_idx;
  logic log_shown, next_log_shown;

  function automatic logic [3:0] clamp_presses(input logic [3:0] n, input sbm_pkg::sbm_page_t p);
    logic [3:0] m;
    m = 4'(sbm_pkg::page_max(p));
    clamp_presses = (n > m) ? m : n;
  endfunction

  wire sec_done = (tick == 32'(CYC_SEC - 1));
  wire [31:0] phase_len = red_mode ? 32'(CYC_RED) : 32'(CYC_GRN);
  wire [3:0] cnt = clamp_presses(presses, page);

  always_comb
  begin
    next_state = state;
    next_page = page;
    next_tick = tick + 32'h0000_0001;
    next_secs = secs;
    next_presses = presses;
    next_blinks = blinks;
    next_red_mode = red_mode;
    next_cfg = cfg;
    next_inter_act = inter_act;
    next_cmd = '0;
    next_log_idx = log_idx;
    next_log_shown = log_shown;
    if (sec_done && (state != SBM_PAGE_BLINK) && (state != SBM_CONFIRM))
    begin
      next_tick = '0;
      next_secs = secs + 6'h01;
    end
    // Intermittent setting is latched into effect on these events and on the shutdown test
    if ((ht & ~ht_prev) | i_flame_loss)
      next_inter_act = cfg.inter_code;
    case (state)
      SBM_IDLE:
      begin
        next_tick = '0;
        next_secs = '0;
        // Entry is independent of burner state
        if (btn_rise)
          next_state = SBM_HOLD;
      end
      SBM_HOLD:
      begin
        if (secs >= 6'(sbm_pkg::S_FAULT) && sec_done)
          next_state = SBM_FAULT;
        else if (btn_fall)
        begin
          next_tick = '0;
          next_secs = '0;
          next_presses = '0;
          // Holds of 15..19 s belong to no page and are ignored
          if (secs < 6'(sbm_pkg::S_HOLD_PAGE) || secs >= 6'(sbm_pkg::PAGE_MAX_S) || (secs >= 6'h0F && secs < 6'h14))
            next_state = SBM_IDLE;
          else
          begin
            next_page = (secs < 6'h0F) ? sbm_pkg::sbm_page_t'(3'(secs / 6'(sbm_pkg::S_HOLD_PAGE)))
                        : sbm_pkg::sbm_page_t'(3'(secs / 6'(sbm_pkg::S_HOLD_PAGE) - 6'h01));
            next_state = SBM_PAGE_BLINK;
            if (secs < 6'd10)
            begin
              next_red_mode = 1'b1;
              next_blinks = 5'(2 * sbm_pkg::RED_BLINKS);
            end
            else
            begin
              // Pages open with 1,3,4,5,6,7 green blinks; purge page has one
              next_red_mode = 1'b0;
              next_blinks = (secs < 6'h0F) ? 5'h02 : 5'(2 * (secs / 6'(sbm_pkg::S_HOLD_PAGE) - 1));
            end
          end
        end
      end
      SBM_PAGE_BLINK:
      begin
        if (tick == phase_len - 32'h0000_0001)
        begin
          next_tick = '0;
          next_blinks = blinks - 5'h01;
          if (blinks == 5'h01)
          begin
            next_secs = '0;
            if (page == sbm_pkg::SBM_PG_SHUT)
            begin
              next_cmd.shut_test = 1'b1;
              next_inter_act = cfg.inter_code;
              next_state = SBM_IDLE;
            end
            else if (page == sbm_pkg::SBM_PG_LOG)
            begin
              next_log_idx = 4'h1;
              next_log_shown = 1'b1;
              next_state = SBM_SHOW;
            end
            else
              next_state = SBM_ENTRY;
          end
        end
      end
      SBM_ENTRY:
      begin
        if (btn_rise)
        begin
          next_secs = '0;
          next_tick = '0;
          if (presses != 4'hF)
            next_presses = presses + 4'h1;
        end
        if (page == sbm_pkg::SBM_PG_PURGE && ~ht && ht_prev)
          next_state = SBM_IDLE;
        else if (!btn && secs >= 6'(sbm_pkg::S_IDLE))
        begin
          next_tick = '0;
          next_red_mode = 1'b0;
          if (page == sbm_pkg::SBM_PG_LOG)
          begin
            if (presses == 4'h0)
              next_state = SBM_IDLE;
            else
            begin
              next_log_idx = cnt;
              next_log_shown = 1'b1;
              next_secs = '0;
              next_state = SBM_SHOW;
            end
          end
          else
          begin
            next_state = SBM_CONFIRM;
            if (presses == 4'h0)
            begin
              // No press: show the stored value instead; reset page exits
              case (page)
                sbm_pkg::SBM_PG_PURGE: next_blinks = 5'({cfg.purge_code, 1'b0});
                sbm_pkg::SBM_PG_INTER: next_blinks = 5'({cfg.inter_code, 1'b0});
                sbm_pkg::SBM_PG_DELAY: next_blinks = 5'({cfg.delay_code, 1'b0});
                sbm_pkg::SBM_PG_LONG: next_blinks = cfg.long_purge ? 5'h02 : 5'h04;
                default: next_state = SBM_IDLE;
              endcase
            end
            else
            begin
              next_blinks = 5'({cnt, 1'b0});
              case (page)
                sbm_pkg::SBM_PG_PURGE: next_cfg.purge_code = cnt;
                sbm_pkg::SBM_PG_INTER: next_cfg.inter_code = 2'(cnt);
                sbm_pkg::SBM_PG_DELAY: next_cfg.delay_code = 2'(cnt);
                sbm_pkg::SBM_PG_LONG: next_cfg.long_purge = (cnt == 4'h1);
                sbm_pkg::SBM_PG_CLEAR:
                begin
                  next_cmd.clr_log = (cnt == 4'h1);
                  next_cmd.clr_lock_cnt = (cnt == 4'h2);
                  next_cmd.clr_hours = (cnt == 4'h3);
                  next_cmd.clr_heat_cnt = (cnt == 4'h4);
                  if (cnt == 4'h5)
                  begin
                    next_cfg.purge_code = sbm_pkg::PP_DEFAULT;
                    next_cfg.inter_code = sbm_pkg::IM_DEFAULT;
                    next_cfg.delay_code = sbm_pkg::SD_DEFAULT;
                    next_cfg.long_purge = sbm_pkg::LP_DEFAULT;
                  end
                end
                default: ;
              endcase
            end
          end
        end
      end
      SBM_CONFIRM:
      begin
        // Value already stored, so heat request loss here keeps it
        if (tick == phase_len - 32'h0000_0001)
        begin
          next_tick = '0;
          next_blinks = blinks - 5'h01;
          if (blinks <= 5'h01)
            next_state = SBM_IDLE;
        end
      end
      SBM_SHOW:
      begin
        if (btn_rise)
        begin
          next_secs = '0;
          next_tick = '0;
          next_presses = '0;
          next_log_shown = 1'b0;
          next_state = SBM_ENTRY;
        end
        else if (secs >= 6'(sbm_pkg::S_IDLE))
        begin
          // Show ends; entry level waits 10 s more before closing
          next_secs = '0;
          next_presses = '0;
          next_log_shown = 1'b0;
          next_state = SBM_ENTRY;
        end
      end
      SBM_FAULT:
      begin
        if (!btn)
          next_state = SBM_IDLE;
      end
      default: next_state = SBM_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state <= SBM_IDLE;
      page <= sbm_pkg::SBM_PG_NONE;
      tick <= '0;
      secs <= '0;
      presses <= '0;
      blinks <= '0;
      red_mode <= 1'b0;
      cfg <= '{sbm_pkg::PP_DEFAULT, sbm_pkg::IM_DEFAULT, sbm_pkg::SD_DEFAULT, sbm_pkg::LP_DEFAULT};
      inter_act <= sbm_pkg::IM_DEFAULT;
      o_cmd <= '0;
      log_idx <= 4'h1;
      log_shown <= 1'b0;
    end
    else
    begin
      state <= next_state;
      page <= next_page;
      tick <= next_tick;
      secs <= next_secs;
      presses <= next_presses;
      blinks <= next_blinks;
      red_mode <= next_red_mode;
      cfg <= next_cfg;
      inter_act <= next_inter_act;
      o_cmd <= next_cmd;
      log_idx <= next_log_idx;
      log_shown <= next_log_shown;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Indicator and outputs
  wire blink_on = blinks[0] == 1'b0 && blinks != 5'h00;
  logic led_r, led_g, shown_lat;
  logic [3:0] shown_type;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      led_r <= 1'b0;
      led_g <= 1'b0;
      shown_type <= '0;
      shown_lat <= 1'b0;
    end
    else
    begin
      led_r <= (state == SBM_PAGE_BLINK) && red_mode && blink_on;
      led_g <= (((state == SBM_PAGE_BLINK) && !red_mode) || state == SBM_CONFIRM) ? blink_on
               : (state == SBM_ENTRY) && btn;
      shown_type <= i_log_type;
      shown_lat <= log_shown;
    end
  end
  assign o_led_red = led_r;
  assign o_led_green = led_g;
  assign o_button_fault = (state == SBM_FAULT);
  assign o_cfg = cfg;
  assign o_inter_active = inter_act;
  assign o_log_index = log_idx;
  assign o_log_show = shown_lat;
  assign o_log_shown_type = shown_type;

  ////////////////////////////////////////////////////////////////////////////
  shut_no_confirm_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state == SBM_PAGE_BLINK && page == sbm_pkg::SBM_PG_SHUT) |=> state != SBM_CONFIRM)
    else $error("shutdown page led to confirmation");
  shut_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_cmd.shut_test |-> $past(page) == sbm_pkg::SBM_PG_SHUT && state == SBM_IDLE)
    else $error("shutdown command from wrong page");
  red_only_shut_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_led_red |-> page == sbm_pkg::SBM_PG_SHUT)
    else $error("red led outside shutdown page");
  entry_led_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state == SBM_ENTRY && $past(state) == SBM_ENTRY) |-> o_led_green == $past(btn))
    else $error("green does not follow button");
  clamp_max_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_cfg.purge_code <= 4'h8 && o_cfg.delay_code <= 2'h3 && o_cfg.inter_code <= 2'h2)
    else $error("setting above page maximum");
  purge_drop_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (state == SBM_ENTRY && page == sbm_pkg::SBM_PG_PURGE && ~ht && ht_prev) |=> state == SBM_IDLE && $stable(o_cfg))
    else $error("post-purge entry not discarded");
  inter_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (!(ht & ~ht_prev) && !i_flame_loss && !(state == SBM_PAGE_BLINK && blinks == 5'h01)) |=> $stable(o_inter_active))
    else $error("intermittent setting applied early");
  fault_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    o_button_fault |-> btn || $past(btn))
    else $error("button fault without long press");
endmodule // sbm_menu

// *** sim/sbm_operator.sv ***
// Partner model: an operator pressing the reset button, plus the lockout log memory.
// Assumes one clock shared with the menu; requests arrive as a one-cycle go pulse.
`timescale 1ns/1ps
module sbm_operator #(
  parameter int CYC_SEC = 100
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_go,
  input wire logic [31:0] i_hold,
  input wire logic [3:0] i_log_index,
  output logic o_button,
  output logic o_busy,
  output logic [3:0] o_log_type
);
  logic [31:0] cnt;

  ////////////////////////////////////////////////////////////////
  // Arbitrary pattern so each entry reads back a distinct type
  assign o_log_type = i_log_index ^ 4'h5;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_button <= 1'b0;
      o_busy <= 1'b0;
      cnt <= 32'h0000_0000;
    end
    else if (i_go && !o_busy)
    begin
      o_button <= 1'b1;
      o_busy <= 1'b1;
      cnt <= i_hold;
    end
    else if (cnt != 32'h0000_0000)
      cnt <= cnt - 32'h0000_0001;
    else if (o_button)
    begin
      // A full second of rest after release so the next press counts
      o_button <= 1'b0;
      cnt <= 32'(CYC_SEC);
    end
    else
      o_busy <= 1'b0;
  end
endmodule // sbm_operator

// *** sim/sbm_menu_tb.sv ***
// Self-checking bench for the setup menu: hold-time decoding, refusals, button fault.
// Assumes seconds shrunk to CS cycles and blink phases shrunk to a few tens of cycles.
`timescale 1ns/1ps
module sbm_menu_tb;
  localparam int CS = 100;
  localparam sbm_pkg::sbm_cfg_t CFG_DEF = '{purge_code: sbm_pkg::PP_DEFAULT, inter_code: sbm_pkg::IM_DEFAULT,
    delay_code: sbm_pkg::SD_DEFAULT, long_purge: sbm_pkg::LP_DEFAULT};
  logic i_clk_sys;
  logic i_reset;
  logic i_heat_request_thermostat;
  logic i_flame_loss;
  logic go;
  logic [31:0] hold;
  logic busy;
  logic button;
  logic [3:0] log_index;
  logic [3:0] log_type;
  logic log_show;
  logic [3:0] shown_type;
  logic led_red;
  logic led_green;
  logic fault;
  logic [1:0] inter_active;
  sbm_pkg::sbm_cfg_t cfg;
  sbm_pkg::sbm_cmd_t cmd;
  int miscompares = 0;
  int checked = 0;

  ////////////////////////////////////////////////////////////////
  sbm_menu #(.CYC_SEC(CS), .CYC_RED(20), .CYC_GRN(50)) i_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_button(button),
    .i_heat_request_thermostat(i_heat_request_thermostat), .i_flame_loss(i_flame_loss),
    .i_log_type(log_type), .o_log_index(log_index), .o_log_show(log_show), .o_log_shown_type(shown_type),
    .o_led_red(led_red), .o_led_green(led_green), .o_button_fault(fault), .o_cfg(cfg),
    .o_inter_active(inter_active), .o_cmd(cmd));
  sbm_operator #(.CYC_SEC(CS)) i_oper (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_go(go), .i_hold(hold),
    .i_log_index(log_index), .o_button(button), .o_busy(busy), .o_log_type(log_type));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset();
    i_reset <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(posedge i_clk_sys);
  endtask

  // Returns once the operator has let go; a stuck operator ends the run
  task automatic wait_release(input int bound);
    int n;
    n = 0;
    while (!(busy === 1'b1 && button === 1'b0) && n < bound)
    begin
      @(posedge i_clk_sys);
      n++;
    end
    if (n >= bound)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, button, 1'b0);
      end_sim();
    end
  endtask

  // The operator ignores a request while it rests after the last release
  task automatic press(input int cyc);
    int n;
    n = 0;
    while (busy === 1'b1 && n < 3 * CS)
    begin
      @(posedge i_clk_sys);
      n++;
    end
    hold <= 32'(cyc);
    go <= 1'b1;
    @(posedge i_clk_sys);
    go <= 1'b0;
    wait_release(cyc + 2 * CS);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    check(32'(cfg), 32'(CFG_DEF));
    check(32'(inter_active), 32'(sbm_pkg::IM_DEFAULT));
    check(32'({led_red, led_green, fault, cmd}), 32'h0000_0000);
    i_flame_loss <= 1'b1;
    @(posedge i_clk_sys);
    i_flame_loss <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    check(32'(inter_active), 32'(sbm_pkg::IM_DEFAULT));
  endtask

  // Holds outside every page window must leave lamps, commands and settings alone
  task automatic t_ignored(input int cyc);
    logic any;
    press(cyc);
    any = 1'b0;
    repeat (60)
    begin
      @(posedge i_clk_sys);
      any = any | led_red | led_green | (|cmd);
    end
    check(32'(any), 32'h0000_0000);
    check(32'(cfg), 32'(CFG_DEF));
  endtask

  // Just past each lower bound; alternate standby and operating heat request
  task automatic t_pages();
    int lo[7] = '{5, 10, 20, 25, 30, 35, 40};
    logic r;
    logic g;
    for (int p = 0; p < 7; p++)
    begin
      i_heat_request_thermostat <= p[0];
      press(lo[p] * CS + 20);
      r = 1'b0;
      g = 1'b0;
      repeat (40)
      begin
        @(posedge i_clk_sys);
        r = r | led_red;
        g = g | led_green;
      end
      check(32'({r, g}), (p == 0) ? 32'h0000_0002 : 32'h0000_0001);
      check(32'(cmd), 32'h0000_0000);
      do_reset();
    end
  endtask

  // Three counted presses on the post-purge page, then three confirmation blinks
  task automatic t_purge();
    int rises;
    logic prev;
    do_reset();
    press(10 * CS + 20);
    repeat (CS) @(posedge i_clk_sys);
    repeat (3) press(CS);
    repeat (10) @(posedge i_clk_sys);
    rises = 0;
    prev = led_green;
    repeat (14 * CS)
    begin
      @(posedge i_clk_sys);
      rises = rises + int'(led_green & ~prev);
      prev = led_green;
    end
    check(32'(rises), 32'h0000_0003);
    check(32'(cfg.purge_code), 32'h0000_0003);
  endtask

  task automatic t_fault();
    int n;
    hold <= 32'(62 * CS);
    go <= 1'b1;
    @(posedge i_clk_sys);
    go <= 1'b0;
    repeat (59 * CS) @(posedge i_clk_sys);
    check(32'(fault), 32'h0000_0000);
    n = 0;
    while (fault !== 1'b1 && n < 3 * CS)
    begin
      @(posedge i_clk_sys);
      n++;
    end
    check(32'(fault), 32'h0000_0001);
    wait_release(4 * CS);
    repeat (40) @(posedge i_clk_sys);
    check(32'({fault, led_red, led_green}), 32'h0000_0000);
    check(32'(cfg), 32'(CFG_DEF));
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    i_reset = 1'b1;
    i_heat_request_thermostat = 1'b0;
    i_flame_loss = 1'b0;
    go = 1'b0;
    hold = 32'h0000_0000;
    @(posedge i_clk_sys);
    do_reset();
    t_reset_values();
    t_ignored(4 * CS + 80);
    t_ignored(45 * CS + 20);
    t_ignored(17 * CS + 20);
    t_pages();
    t_purge();
    do_reset();
    t_fault();
    end_sim();
  end
endmodule // sbm_menu_tb
